// ---- jlp_defines.svh ----
// Register indices, field positions, reset values and bus constants of the link parameter bank.
`ifndef JLP_DEFINES_SVH
`define JLP_DEFINES_SVH

// Printed offsets are register indices; byte address is four times the index.
`define JLP_IDX_CS_RES 12'h058F
`define JLP_IDX_SC_NP 12'h0590
`define JLP_IDX_SPF 12'h0591
`define JLP_IDX_HD_CF 12'h0592

`define JLP_ADDR_W 16

`define JLP_CS_MSB 7
`define JLP_CS_LSB 6
`define JLP_RES_MSB 4
`define JLP_RES_LSB 0
`define JLP_SC_MSB 7
`define JLP_SC_LSB 5
`define JLP_NP_MSB 4
`define JLP_NP_LSB 0
`define JLP_SPF_RSV_MSB 7
`define JLP_SPF_RSV_LSB 5
`define JLP_SPF_MSB 4
`define JLP_SPF_LSB 0
`define JLP_HD_BIT 7
`define JLP_CF_MSB 4
`define JLP_CF_LSB 0

`define JLP_CS_RST 2'h0
`define JLP_RES_RST 5'h0F
`define JLP_SC_RST 3'h1
`define JLP_NP_RST 5'h0F
`define JLP_SPF_RSV_VAL 3'h1
`define JLP_SPF_RST 5'h00
`define JLP_CF_RST 5'h00

`define JLP_CS_TWO 2'h2
`define JLP_CS_THREE 2'h3
`define JLP_SC_ZERO 3'h0
`define JLP_SC_ONE 3'h1
`define JLP_RES_14BIT 5'h0D
`define JLP_NP_8 5'h07
`define JLP_NP_12 5'h0B
`define JLP_NP_16 5'h0F

`endif

// ---- jlp_pkg.sv ----
// Types shared by the link parameter bank modules.
`default_nettype none
package jlp_pkg;

  // Writable framing configuration handed to the link transmitter.
  typedef struct packed {
    logic [1:0] ctrlBits;
    logic [4:0] resolution;
    logic [2:0] subclass;
    logic [4:0] sampleBits;
  } jlp_cfg_t;

  // Framing state reported back by the link transmitter.
  typedef struct packed {
    logic [4:0] samplesPerFrame;
    logic highDensity;
    logic [4:0] ctrlWords;
  } jlp_stat_t;

  typedef struct packed {
    logic [15:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } jlp_apb_req_t;

endpackage
`default_nettype wire

// ---- jlp_status_capture.sv ----
// Captures the framing logic's read-only parameters with a defined reset value.
`include "jlp_defines.svh"
`default_nettype none
module jlp_status_capture (
  input wire logic clk,
  input wire logic sys_rst,
  input wire jlp_pkg::jlp_stat_t statIn,
  output jlp_pkg::jlp_stat_t statOut
);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      statOut.samplesPerFrame <= `JLP_SPF_RST;
      statOut.highDensity <= 1'b0;
      statOut.ctrlWords <= `JLP_CF_RST;
    end else begin
      statOut <= statIn;
    end
  end

endmodule
`default_nettype wire

// ---- jlp_link_param_regs.sv ----
// APB register bank for the serial link framing parameters.
//
// Behaviour
// - Control-bit count 2 or 3 selects upper control bits.
// - Resolution code is bits minus one, resets 0xF.
// - Bits-per-sample writable, codes 7, 11, 15.
// - Samples-per-frame read-only, minus one, resets zero.
// - Read-only high-density flag, one when enabled.
// - Read-only control words per frame cycle.
//
// Implementation choice: the APB interface to the registers.
`include "jlp_defines.svh"
`default_nettype none
module jlp_link_param_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire jlp_pkg::jlp_apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire jlp_pkg::jlp_stat_t linkStat,
  output jlp_pkg::jlp_cfg_t linkCfg,
  output logic [2:0] ctrlBitSelect,
  output logic subclassOne,
  output logic [4:0] resolutionBits,
  output logic [4:0] sampleWidth
);

  jlp_pkg::jlp_stat_t statCap;
  logic [1:0] ctrlBits_r;
  logic [4:0] resolution_r;
  logic [2:0] subclass_r;
  logic [4:0] sampleBits_r;
  logic [31:0] prdata_r;
  logic [2:0] ctrlBitSelect_r;
  logic subclassOne_r;
  logic [4:0] resolutionBits_r;
  logic [4:0] sampleWidth_r;
  logic setupPhase;
  logic accessPhase;
  logic mapped;
  logic wrEn;
  logic lane0;
  logic [7:0] wByte;

  // Returns the register index for an aligned word address, or all ones if unaligned.
  function automatic logic [11:0] word_index(input logic [15:0] addr);
    if (addr[1:0] != 2'b00) begin
      return 12'hFFF;
    end
    return addr[13:2];
  endfunction

  // Tells whether a byte address selects one of the four registers.
  function automatic logic is_mapped(input logic [15:0] addr);
    logic [11:0] idx;
    idx = word_index(addr);
    if (addr[15:14] != 2'b00) begin
      return 1'b0;
    end else if (idx == `JLP_IDX_CS_RES) begin
      return 1'b1;
    end else if (idx == `JLP_IDX_SC_NP) begin
      return 1'b1;
    end else if (idx == `JLP_IDX_SPF) begin
      return 1'b1;
    end else if (idx == `JLP_IDX_HD_CF) begin
      return 1'b1;
    end
    return 1'b0;
  endfunction

  jlp_status_capture uStat (
    .clk(clk),
    .sys_rst(sys_rst),
    .statIn(linkStat),
    .statOut(statCap)
  );

  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessPhase = apbReq.psel && apbReq.penable;
  assign mapped = is_mapped(apbReq.paddr);
  // Only the low byte lane holds register bits; a write without it changes nothing.
  assign lane0 = apbReq.pstrb[0];
  assign wByte = apbReq.pwdata[7:0];
  assign wrEn = accessPhase && apbReq.pwrite && mapped && lane0;

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign pslverr = accessPhase && !mapped;
  assign prdata = prdata_r;

  // Control bits and resolution register; bit 5 is reserved.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrlBits_r <= `JLP_CS_RST;
      resolution_r <= `JLP_RES_RST;
    end else if (wrEn && word_index(apbReq.paddr) == `JLP_IDX_CS_RES) begin
      ctrlBits_r <= wByte[`JLP_CS_MSB:`JLP_CS_LSB];
      resolution_r <= wByte[`JLP_RES_MSB:`JLP_RES_LSB];
    end
  end

  // Subclass and transmitted bits-per-sample register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      subclass_r <= `JLP_SC_RST;
      sampleBits_r <= `JLP_NP_RST;
    end else if (wrEn && word_index(apbReq.paddr) == `JLP_IDX_SC_NP) begin
      subclass_r <= wByte[`JLP_SC_MSB:`JLP_SC_LSB];
      sampleBits_r <= wByte[`JLP_NP_MSB:`JLP_NP_LSB];
    end
  end

  // Read data is fetched in the setup cycle so it stands through the access cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPhase && !apbReq.pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (word_index(apbReq.paddr) == `JLP_IDX_CS_RES && mapped) begin
        prdata_r[`JLP_CS_MSB:`JLP_CS_LSB] <= ctrlBits_r;
        prdata_r[`JLP_RES_MSB:`JLP_RES_LSB] <= resolution_r;
      end else if (word_index(apbReq.paddr) == `JLP_IDX_SC_NP && mapped) begin
        prdata_r[`JLP_SC_MSB:`JLP_SC_LSB] <= subclass_r;
        prdata_r[`JLP_NP_MSB:`JLP_NP_LSB] <= sampleBits_r;
      end else if (word_index(apbReq.paddr) == `JLP_IDX_SPF && mapped) begin
        prdata_r[`JLP_SPF_RSV_MSB:`JLP_SPF_RSV_LSB] <= `JLP_SPF_RSV_VAL;
        prdata_r[`JLP_SPF_MSB:`JLP_SPF_LSB] <= statCap.samplesPerFrame;
      end else if (word_index(apbReq.paddr) == `JLP_IDX_HD_CF && mapped) begin
        prdata_r[`JLP_HD_BIT] <= statCap.highDensity;
        prdata_r[`JLP_CF_MSB:`JLP_CF_LSB] <= statCap.ctrlWords;
      end
    end
  end

  // Decoded framing controls for the transmitter, registered.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrlBitSelect_r <= 3'b000;
      subclassOne_r <= 1'b1;
      resolutionBits_r <= 5'h10;
      sampleWidth_r <= 5'h10;
    end else begin
      // Bit 2 is control bit 2; two bits use the upper two, three use all.
      if (ctrlBits_r == `JLP_CS_THREE) begin
        ctrlBitSelect_r <= 3'b111;
      end else if (ctrlBits_r == `JLP_CS_TWO) begin
        ctrlBitSelect_r <= 3'b110;
      end else if (ctrlBits_r == 2'h1) begin
        ctrlBitSelect_r <= 3'b100;
      end else begin
        ctrlBitSelect_r <= 3'b000;
      end
      subclassOne_r <= (subclass_r == `JLP_SC_ONE);
      resolutionBits_r <= resolution_r + 5'h01;
      sampleWidth_r <= sampleBits_r + 5'h01;
    end
  end

  assign ctrlBitSelect = ctrlBitSelect_r;
  assign subclassOne = subclassOne_r;
  assign resolutionBits = resolutionBits_r;
  assign sampleWidth = sampleWidth_r;
  assign linkCfg.ctrlBits = ctrlBits_r;
  assign linkCfg.resolution = resolution_r;
  assign linkCfg.subclass = subclass_r;
  assign linkCfg.sampleBits = sampleBits_r;

endmodule
`default_nettype wire

// ---- jlp_regs_props.sv ----
// Concurrent checks on the ports of the link parameter bank.
`default_nettype none
module jlp_regs_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire jlp_pkg::jlp_apb_req_t apbReq,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire jlp_pkg::jlp_stat_t linkStat,
  input wire jlp_pkg::jlp_cfg_t linkCfg,
  input wire logic [2:0] ctrlBitSelect,
  input wire logic subclassOne,
  input wire logic [4:0] resolutionBits,
  input wire logic [4:0] sampleWidth
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr_s(a);
    apbReq.psel && apbReq.penable && apbReq.pwrite && apbReq.pstrb[0] && apbReq.paddr == a;
  endsequence
  sequence rd_s(a);
    apbReq.psel && !apbReq.penable && !apbReq.pwrite && apbReq.paddr == a && !$past(sys_rst);
  endsequence
  cs_two_a: assert property (linkCfg.ctrlBits == 2'h2 |=> ctrlBitSelect == 3'h6)
    else $error("two control bits not mapped");
  cs_three_a: assert property (linkCfg.ctrlBits == 2'h3 |=> ctrlBitSelect == 3'h7)
    else $error("three control bits not mapped");
  res_bits_a: assert property (1 |=> resolutionBits == $past(linkCfg.resolution) + 5'h01)
    else $error("resolution output wrong");
  np_write_a: assert property (wr_s(16'h1640) |=> linkCfg.sampleBits == $past(apbReq.pwdata[4:0]))
    else $error("sample bits not written");
  spf_read_a: assert property (rd_s(16'h1644) |=> prdata[7:0] ==
    {3'h1, $past(linkStat.samplesPerFrame, 2)}) else $error("samples per frame read wrong");
  spf_ro_a: assert property (wr_s(16'h1644) |=> $stable(linkCfg))
    else $error("read-only write changed config");
  hd_cf_read_a: assert property (rd_s(16'h1648) |=> prdata[7:0] ==
    {$past(linkStat.highDensity, 2), 2'h0, $past(linkStat.ctrlWords, 2)})
    else $error("density or control words wrong");
  sc_one_a: assert property (1 |=> subclassOne == ($past(linkCfg.subclass) == 3'h1))
    else $error("subclass flag wrong");
endmodule
bind jlp_link_param_regs jlp_regs_props i_jlp_regs_props (.clk(clk), .sys_rst(sys_rst),
  .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .linkStat(linkStat),
  .linkCfg(linkCfg), .ctrlBitSelect(ctrlBitSelect), .subclassOne(subclassOne),
  .resolutionBits(resolutionBits), .sampleWidth(sampleWidth));
`default_nettype wire

// ---- test_jlp_link_param_regs.sv ----
// Self-checking bench for the link parameter bank.
`default_nettype none
module test_jlp_link_param_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sysRst, pready, pslverr, sc1, err;
  jlp_pkg::jlp_apb_req_t req;
  jlp_pkg::jlp_stat_t stat;
  jlp_pkg::jlp_cfg_t cfg;
  logic [31:0] prdata, rd;
  logic [2:0] cbs;
  logic [4:0] resB, sw;
  int err_total, n_tests, cyc;
  jlp_link_param_regs i_jlp_link_param_regs (.clk(clk), .sys_rst(sysRst), .apbReq(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .linkStat(stat), .linkCfg(cfg),
    .ctrlBitSelect(cbs), .subclassOne(sc1), .resolutionBits(resB), .sampleWidth(sw));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, then one idle cycle so the next setup never collides with the release.
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}, pstrb: 4'hF};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    apb(0, 16'h163C, 0); check("res", rd, 32'h0000_000F);
    apb(0, 16'h1640, 0); check("scnp", rd, 32'h0000_002F);
    check("sc1", sc1, 32'h0000_0001);
    apb(0, 16'h1644, 0); check("spf", rd, 32'h0000_0020);
    apb(0, 16'h1648, 0); check("hd0", rd, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_cfg();
    logic [4:0] np[3] = '{5'h07, 5'h0B, 5'h0F};
    apb(1, 16'h163C, 8'h8D); apb(0, 16'h163C, 0); check("cs2", rd, 32'h0000_008D);
    check("cbs2", cbs, 32'h0000_0006);
    check("resb", resB, 32'h0000_000E);
    check("cfgres", cfg.resolution, 32'h0000_000D);
    check("cfgcs", cfg.ctrlBits, 32'h0000_0002);
    apb(1, 16'h163C, 8'hCD); apb(0, 16'h163C, 0); check("cbs3", cbs, 32'h0000_0007);
    foreach (np[i]) begin
      apb(1, 16'h1640, {3'h0, np[i]}); apb(0, 16'h1640, 0);
      check("np", rd, {27'h0, np[i]});
      check("sw", sw, {27'h0, np[i] + 5'h01});
      check("sc0", sc1, 32'h0000_0000);
    end
    apb(1, 16'h1640, 8'h2B); apb(0, 16'h1640, 0); check("sc1b", sc1, 32'h0000_0001);
    $display("test config done");
  endtask
  task automatic t_stat();
    stat <= '{samplesPerFrame: 5'h03, highDensity: 1'b1, ctrlWords: 5'h05};
    repeat (2) @(posedge clk);
    apb(1, 16'h1644, 8'hFF); apb(0, 16'h1644, 0); check("spf", rd, 32'h0000_0023);
    apb(0, 16'h1648, 0); check("hdcf", rd, 32'h0000_0085);
    apb(0, 16'h1650, 0); check("unmapped", {rd[30:0], err}, 32'h0000_0001);
    $display("test status done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    sysRst = 1;
    req = '0;
    stat = '0;
    repeat (10) @(posedge clk);
    sysRst <= 0;
    @(posedge clk);
    t_reset();
    t_cfg();
    t_stat();
    end_of_test();
  end
endmodule
`default_nettype wire
